// file: pkg/tts_pkg.sv
// Constants and carrier types for the touch channel role select registers
package tts_pkg;
	localparam int unsigned TTS_ADDR_W = 20;
	localparam int unsigned TTS_DATA_W = 8;
	localparam int unsigned TTS_CHAN_N = 15;
	localparam logic [19:0] TTS_ADDR_SEL_LO = 20'hf038b;
	localparam logic [19:0] TTS_ADDR_SEL_HI = 20'hf038c;
	localparam logic [7:0] TTS_RST_SEL_LO = 8'h00;
	localparam logic [7:0] TTS_RST_SEL_HI = 8'h00;
	localparam logic [7:0] TTS_WMASK_LO = 8'hff;
	localparam logic [7:0] TTS_WMASK_HI = 8'h7f;
	localparam int unsigned TTS_HI_CHAN_BASE = 8;
	localparam int unsigned TTS_HI_CHAN_N = 7;
	localparam int unsigned TTS_HI_RSVD_BIT = 7;
	localparam logic [1:0] TTS_MODE_MUTUAL_FULL = 2'h3;
	localparam logic [7:0] TTS_BIT_ONE = 8'h01;

	typedef struct packed {
		logic wr;
		logic rd;
		logic bit_op;
		logic [2:0] bit_sel;
		logic [19:0] addr;
		logic [7:0] wdata;
	} tts_sfr_req_s;

	typedef struct packed {
		logic rd_valid;
		logic [7:0] rdata;
	} tts_sfr_rsp_s;
endpackage

// file: src/tts_sel_reg.sv
// One 8-bit selection register with byte and single-bit write
`timescale 1ns/1ps
module tts_sel_reg import tts_pkg::*; #(
	parameter logic [7:0] WMASK = 8'hff,
	parameter logic [7:0] RST_VAL = 8'h00
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Write strobes
	input wire logic wr_byte,
	input wire logic wr_bit,
	input wire logic [2:0] bit_sel,
	input wire logic [7:0] wdata,
	// Stored value
	output logic [7:0] q
);
	logic [7:0] val_ff;
	logic [7:0] nxt_val;
	logic [7:0] bit_mask;

	always_comb begin
		bit_mask = TTS_BIT_ONE << bit_sel;
		nxt_val = val_ff;
		if (wr_byte) begin
			nxt_val = wdata & WMASK;
		end else if (wr_bit) begin
			// Only the addressed bit moves; value taken from data bit 0
			nxt_val = (val_ff & ~bit_mask) |
				({8{wdata[0]}} & bit_mask & WMASK);
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			val_ff <= RST_VAL;
		end else begin
			val_ff <= nxt_val;
		end
	end

	assign q = val_ff;
endmodule

// file: src/tts_txrx_select.sv
// Per-channel transmit/receive role selection for the touch sensing unit
//
// Overview of operation
// - Channel bit 1 drives its sense pin as transmitter, 0 as receiver.
// - Role selection applies only in mutual capacitance full scan mode.
// - Low select register bit n controls channel n, n 0 to 7.
// - High register bits 0 to 6 control channels 8 to 14 ascending.
// - Reset clears both registers, all channels default to receiver.
// - Byte and single-bit writes accepted; bit write changes only that bit.
// - Mutual full scan mode means the mode field equals binary 11.
`timescale 1ns/1ps
module tts_txrx_select import tts_pkg::*; (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Special function register access
	input wire tts_sfr_req_s sfr_req,
	output logic sfr_hit,
	output tts_sfr_rsp_s sfr_rsp,
	// Unit control, same clock domain
	input wire logic [1:0] measure_mode_field,
	input wire logic measure_start_bit,
	// Sense pin roles, bit n is channel n, 1 = transmit
	output logic [14:0] pin_role_tx,
	output logic full_scan_active
);
	logic hit_lo;
	logic hit_hi;
	logic wr_lo_byte;
	logic wr_hi_byte;
	logic wr_lo_bit;
	logic wr_hi_bit;
	logic [7:0] lo_q;
	logic [7:0] hi_q;
	logic [7:0] wr_data;
	logic [6:0] wr_data_lo7;
	logic [7:0] bit_mask;
	logic [14:0] sel_all;
	logic full_mode;

	logic [14:0] role_ff;
	logic [14:0] nxt_role;
	logic full_ff;
	logic nxt_full;
	logic rd_valid_ff;
	logic nxt_rd_valid;
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;

	// Address decode
	assign hit_lo = (sfr_req.addr == TTS_ADDR_SEL_LO);
	assign hit_hi = (sfr_req.addr == TTS_ADDR_SEL_HI);
	assign sfr_hit = (hit_lo | hit_hi) & (sfr_req.wr | sfr_req.rd);
	assign wr_data = sfr_req.wdata;
	assign wr_data_lo7 = sfr_req.wdata[6:0];
	assign bit_mask = TTS_BIT_ONE << sfr_req.bit_sel;

	// No lockout while measuring: software owns that ordering
	assign wr_lo_byte = sfr_req.wr & hit_lo & ~sfr_req.bit_op;
	assign wr_lo_bit = sfr_req.wr & hit_lo & sfr_req.bit_op;
	assign wr_hi_byte = sfr_req.wr & hit_hi & ~sfr_req.bit_op;
	assign wr_hi_bit = sfr_req.wr & hit_hi & sfr_req.bit_op;

	tts_sel_reg #(
		.WMASK(TTS_WMASK_LO),
		.RST_VAL(TTS_RST_SEL_LO)
	) u_sel_lo (
		.mclk(mclk),
		.rstn(rstn),
		.wr_byte(wr_lo_byte),
		.wr_bit(wr_lo_bit),
		.bit_sel(sfr_req.bit_sel),
		.wdata(sfr_req.wdata),
		.q(lo_q)
	);

	// Bit 7 write mask keeps the reserved bit at zero even if misused
	tts_sel_reg #(
		.WMASK(TTS_WMASK_HI),
		.RST_VAL(TTS_RST_SEL_HI)
	) u_sel_hi (
		.mclk(mclk),
		.rstn(rstn),
		.wr_byte(wr_hi_byte),
		.wr_bit(wr_hi_bit),
		.bit_sel(sfr_req.bit_sel),
		.wdata(sfr_req.wdata),
		.q(hi_q)
	);

	assign full_mode = (measure_mode_field == TTS_MODE_MUTUAL_FULL);
	// Channels 0..7 from low register, 8..14 from high bits 0..6
	assign sel_all = {hi_q[TTS_HI_CHAN_N-1:0], lo_q};

	// Role outputs
	always_comb begin
		nxt_full = full_mode;
		nxt_role = '0;
		if (full_mode) begin
			nxt_role = sel_all;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			role_ff <= '0;
			full_ff <= 1'b0;
		end else begin
			role_ff <= nxt_role;
			full_ff <= nxt_full;
		end
	end

	assign pin_role_tx = role_ff;
	assign full_scan_active = full_ff;

	// Read path, data one cycle after the read strobe
	always_comb begin
		nxt_rd_valid = sfr_req.rd & (hit_lo | hit_hi);
		nxt_rdata = rdata_ff;
		if (sfr_req.rd & hit_lo) begin
			nxt_rdata = lo_q;
		end else if (sfr_req.rd & hit_hi) begin
			nxt_rdata = {1'b0, hi_q[TTS_HI_CHAN_N-1:0]};
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rd_valid_ff <= 1'b0;
			rdata_ff <= 8'h00;
		end else begin
			rd_valid_ff <= nxt_rd_valid;
			rdata_ff <= nxt_rdata;
		end
	end

	// One driver for the whole response struct
	assign sfr_rsp = '{rd_valid: rd_valid_ff, rdata: rdata_ff};

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	chk_role_follows_sel: assert property (
		full_mode |=> pin_role_tx == $past(sel_all)
	) else $error("tx role does not follow selection in full scan");

	chk_role_idle_mode: assert property (
		!full_mode |=> pin_role_tx == 15'h0000 && !full_scan_active
	) else $error("tx role driven outside full scan mode");

	chk_lo_byte_map: assert property (
		wr_lo_byte ##1 full_mode |=> pin_role_tx[7:0] == $past(wr_data, 2)
	) else $error("low register byte does not reach channels 0 to 7");

	chk_hi_byte_map: assert property (
		wr_hi_byte |=> hi_q[6:0] == $past(wr_data_lo7) && !hi_q[7]
	) else $error("high register byte does not map channels 8 to 14");

	chk_reset_clear: assert property (
		$rose(rstn) |-> lo_q == 8'h00 && hi_q == 8'h00 &&
			pin_role_tx == 15'h0000
	) else $error("selection not cleared by reset");

	chk_bit_write_only: assert property (
		wr_lo_bit |=> ((lo_q ^ $past(lo_q)) & ~$past(bit_mask)) == 8'h00
	) else $error("bit write disturbed other bits");

	chk_mode_decode: assert property (
		measure_mode_field == TTS_MODE_MUTUAL_FULL && sel_all != 15'h0000 |=>
			pin_role_tx != 15'h0000 && full_scan_active
	) else $error("mode 11 not treated as mutual full scan");

	chk_rsvd_read_zero: assert property (
		sfr_req.rd && hit_hi |=> sfr_rsp.rd_valid && !sfr_rsp.rdata[7]
	) else $error("reserved bit of high register read nonzero");

	chk_lo_read_value: assert property (
		sfr_req.rd && hit_lo |=> sfr_rsp.rd_valid && sfr_rsp.rdata == $past(lo_q)
	) else $error("low register read returns wrong value");

	cov_write_then_full: cover property (
		wr_lo_byte ##1 full_mode ##1 pin_role_tx != 15'h0000
	);
	cov_bit_write_hi: cover property (wr_hi_bit ##1 hi_q != 8'h00);
	cov_read_while_run: cover property (
		measure_start_bit && sfr_req.rd && hit_hi
	);
endmodule

// file: verification/tts_txrx_select_tb_top.sv
// Self-checking bench for the channel role select registers
`timescale 1ns/1ps
module tts_txrx_select_tb_top import tts_pkg::*;;
	logic mclk;
	logic rstn;
	tts_sfr_req_s req;
	logic hit;
	tts_sfr_rsp_s rsp;
	logic [1:0] mode;
	logic start;
	logic [14:0] role;
	logic fsa;
	int fails;
	int checked;
	int cycles;

	tts_txrx_select u_dut (
		.mclk(mclk), .rstn(rstn), .sfr_req(req), .sfr_hit(hit),
		.sfr_rsp(rsp), .measure_mode_field(mode),
		.measure_start_bit(start), .pin_role_tx(role),
		.full_scan_active(fsa)
	);

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic cmp(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Request held from one falling edge to the next, taken at the rise
	task automatic wr(input logic [19:0] a, input logic b,
		input logic [2:0] s, input logic [7:0] d);
		@(negedge mclk);
		req = '{wr: 1'b1, rd: 1'b0, bit_op: b, bit_sel: s, addr: a, wdata: d};
		#1 cmp("sfr_hit", 16'h0001, {15'h0, hit});
		@(negedge mclk);
		req = '0;
	endtask

	task automatic rd(input logic [19:0] a, input logic [7:0] exp);
		@(negedge mclk);
		req = '{wr: 1'b0, rd: 1'b1, bit_op: 1'b0, bit_sel: 3'h0, addr: a,
			wdata: 8'h00};
		@(negedge mclk);
		req = '0;
		cmp("rd_valid", 16'h0001, {15'h0, rsp.rd_valid});
		cmp("rdata", {8'h0, exp}, {8'h0, rsp.rdata});
	endtask

	// Roles are registered, so let the update edge pass first
	task automatic role_is(input logic [14:0] exp, input logic act);
		repeat (2) @(negedge mclk);
		cmp("pin_role_tx", {1'b0, exp}, {1'b0, role});
		cmp("full_scan_active", {15'h0, act}, {15'h0, fsa});
	endtask

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 2000) begin
			fails++;
			report_and_stop;
		end
	end

	initial begin
		rstn = 1'b0;
		req = '0;
		mode = 2'h3;
		start = 1'b0;
		repeat (10) @(negedge mclk);
		rstn = 1'b1;
		rd(TTS_ADDR_SEL_LO, TTS_RST_SEL_LO);
		rd(TTS_ADDR_SEL_HI, TTS_RST_SEL_HI);
		wr(TTS_ADDR_SEL_LO, 1'b0, 3'h0, 8'ha5);
		wr(TTS_ADDR_SEL_HI, 1'b0, 3'h0, 8'h7f);
		rd(TTS_ADDR_SEL_HI, 8'h7f);
		role_is(15'h7fa5, 1'b1);
		wr(TTS_ADDR_SEL_HI, 1'b1, 3'h6, 8'h00);
		wr(TTS_ADDR_SEL_LO, 1'b1, 3'h1, 8'h01);
		rd(TTS_ADDR_SEL_LO, 8'ha7);
		rd(TTS_ADDR_SEL_HI, 8'h3f);
		role_is(15'h3fa7, 1'b1);
		// One transmitter walked across every channel
		for (int i = 0; i < 15; i++) begin
			wr(TTS_ADDR_SEL_LO, 1'b0, 3'h0, i < 8 ? 8'h01 << i : 8'h00);
			wr(TTS_ADDR_SEL_HI, 1'b0, 3'h0,
				i < 8 ? 8'h00 : 8'h01 << (i - 8));
			role_is(15'h0001 << i, 1'b1);
		end
		// Stopped, so the other modes never measure with bits set
		for (int m = 0; m < 3; m++) begin
			mode = 2'(m);
			role_is(15'h0000, 1'b0);
		end
		mode = TTS_MODE_MUTUAL_FULL;
		role_is(15'h4000, 1'b1);
		// Reads are fine while measuring; no write is issued while start is set
		start = 1'b1;
		rd(TTS_ADDR_SEL_HI, 8'h40);
		start = 1'b0;
		@(negedge mclk);
		req = '{wr: 1'b0, rd: 1'b1, bit_op: 1'b0, bit_sel: 3'h0,
			addr: 20'hf038d, wdata: 8'h00};
		#1 cmp("unmapped hit", 16'h0000, {15'h0, hit});
		@(negedge mclk);
		req = '0;
		cmp("unmapped valid", 16'h0000, {15'h0, rsp.rd_valid});
		rstn = 1'b0;
		#1 cmp("role in reset", 16'h0000, {1'b0, role});
		@(negedge mclk);
		rstn = 1'b1;
		rd(TTS_ADDR_SEL_HI, TTS_RST_SEL_HI);
		rd(TTS_ADDR_SEL_LO, TTS_RST_SEL_LO);
		report_and_stop;
	end
endmodule
